// ---- logic/nvs_pkg.sv ----
package nvs_pkg;

  // ==========================================================================
  // Pin widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  // ==========================================================================
  // Software sequence addresses
  localparam logic [10:0] SEQ_A0 = 11'h000;
  localparam logic [10:0] SEQ_A1 = 11'h555;
  localparam logic [10:0] SEQ_A2 = 11'h2AA;
  localparam logic [10:0] SEQ_A3 = 11'h7FF;
  localparam logic [10:0] SEQ_A4 = 11'h0F0;
  localparam logic [10:0] SEQ_STORE = 11'h70F;
  localparam logic [10:0] SEQ_RECALL = 11'h70E;

  // ==========================================================================
  // Timing at 250 MHz (4 ns period)
  localparam int CLK_PS = 4000;
  localparam int INIT_NS = 70;
  localparam int PULSE_NS = 60;
  localparam int STORE_MS = 10;
  localparam int RECALL_US = 20;
  localparam int INIT_CYC = (INIT_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int STORE_CYC_DEF = (STORE_MS * 1000000 / CLK_PS) * 1000;
  localparam int RECALL_CYC_DEF = RECALL_US * 1000000 / CLK_PS;
  localparam int CNT_W = 24;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {NVS_OP_STORE, NVS_OP_RECALL} nvs_op_t;

  typedef enum logic [2:0] {
    NVS_IDLE, NVS_SETUP, NVS_LOW, NVS_HIGH, NVS_BUSY
  } nvs_state_t;

  typedef struct packed {
    logic [10:0] addr;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } nvs_pins_t;

  typedef struct packed {
    nvs_state_t st;
    logic [2:0] step;
    nvs_op_t op;
    logic [CNT_W-1:0] cnt;
    nvs_pins_t pins;
    logic done;
    logic busy;
  } nvs_regs_t;

endpackage

// ---- logic/nvs_host_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// R1 - Sequence starts with reads at 000, 555, 2AA, back to back.
// R2 - Reads at 7FF, 0F0, then 70F start a store; device disables itself.
// R3 - Recall uses same five reads, sixth read at 70E.
// R4 - Device erases then programs all nonvolatile cells during store.
// R5 - Device ignores pins while store runs; host stays off the bus.
// R6 - No other access between sequence reads; device aborts otherwise.
// R7 - Host issues only reads; output gate level does not matter.
// R8 - After store time device accepts reads and writes again.
// R9 - Device refuses software store while power fail is active.
// R10 - Writes after power fail are blocked by the device.
// R11 - Recall clears SRAM then copies nonvolatile data.
// R12 - Recall leaves nonvolatile contents unchanged.
// R13 - After recall time device accepts reads and writes again.
// R14 - Write strobe held high while chip select low in the sequence.
// R15 - Each step is a chip-select-controlled read pulse.
// R16 - After abort the device matcher restarts at first address.
// R17 - Store lasts at most 10 ms, recall at most 20 us.
module nvs_host_ctrl #(
  parameter int STORE_CYC = nvs_pkg::STORE_CYC_DEF,
  parameter int RECALL_CYC = nvs_pkg::RECALL_CYC_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire nvs_pkg::nvs_op_t i_op,
  output logic o_ready,
  output logic o_busy,
  output logic o_done,
  output logic [10:0] o_addr,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);

  // ==========================================================================
  // State
  nvs_pkg::nvs_regs_t r_q;
  nvs_pkg::nvs_regs_t r_d;

  function automatic logic [10:0] seq_addr(input logic [2:0] idx, input nvs_pkg::nvs_op_t op);
    logic [10:0] a;
    a = nvs_pkg::SEQ_A0;
    case (idx)
      3'h0: a = nvs_pkg::SEQ_A0; // R1
      3'h1: a = nvs_pkg::SEQ_A1; // R1
      3'h2: a = nvs_pkg::SEQ_A2; // R1
      3'h3: a = nvs_pkg::SEQ_A3; // R2
      3'h4: a = nvs_pkg::SEQ_A4; // R2
      3'h5: a = (op == nvs_pkg::NVS_OP_RECALL) ? nvs_pkg::SEQ_RECALL : nvs_pkg::SEQ_STORE; // R2 R3
      default: a = nvs_pkg::SEQ_A0;
    endcase
    return a;
  endfunction

  // ==========================================================================
  // Sequencer
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    case (r_q.st)
      nvs_pkg::NVS_IDLE: begin
        r_d.pins.ce_n = 1'b1;
        if (i_start) begin
          r_d.op = i_op;
          r_d.step = 3'h0;
          r_d.pins.addr = seq_addr(3'h0, i_op);
          r_d.busy = 1'b1;
          r_d.cnt = '0;
          r_d.st = nvs_pkg::NVS_SETUP;
        end
      end
      nvs_pkg::NVS_SETUP: begin
        // Address is stable one cycle before chip select falls
        r_d.pins.ce_n = 1'b0; // R15
        r_d.cnt = '0;
        r_d.st = nvs_pkg::NVS_LOW;
      end
      nvs_pkg::NVS_LOW: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (r_q.cnt == nvs_pkg::CNT_W'(nvs_pkg::INIT_CYC - 1)) begin
          r_d.pins.ce_n = 1'b1; // R15
          r_d.cnt = '0;
          r_d.st = nvs_pkg::NVS_HIGH;
        end
      end
      nvs_pkg::NVS_HIGH: begin
        if (r_q.step == 3'h5) begin
          r_d.cnt = '0;
          r_d.st = nvs_pkg::NVS_BUSY; // R5
        end else begin
          // Next read follows at once; nothing else touches the bus
          r_d.step = r_q.step + 3'h1; // R6
          r_d.pins.addr = seq_addr(r_q.step + 3'h1, r_q.op);
          r_d.st = nvs_pkg::NVS_SETUP;
        end
      end
      nvs_pkg::NVS_BUSY: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if ((r_q.op == nvs_pkg::NVS_OP_STORE && r_q.cnt == nvs_pkg::CNT_W'(STORE_CYC - 1)) ||
            (r_q.op == nvs_pkg::NVS_OP_RECALL && r_q.cnt == nvs_pkg::CNT_W'(RECALL_CYC - 1))) begin
          r_d.busy = 1'b0; // R8 R13 R17
          r_d.done = 1'b1;
          r_d.cnt = '0;
          r_d.st = nvs_pkg::NVS_IDLE;
        end
      end
      default: begin
        r_d.st = nvs_pkg::NVS_IDLE;
        r_d.pins.ce_n = 1'b1;
        r_d.busy = 1'b0;
      end
    endcase
    r_d.pins.we_n = 1'b1; // R7 R14
    r_d.pins.oe_n = 1'b1; // R7
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_q <= '{st: nvs_pkg::NVS_IDLE, step: 3'h0, op: nvs_pkg::NVS_OP_STORE, cnt: '0,
               pins: '{addr: 11'h000, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}, done: 1'b0, busy: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign o_ready = (r_q.st == nvs_pkg::NVS_IDLE);
  assign o_busy = r_q.busy;
  assign o_done = r_q.done;
  assign o_addr = r_q.pins.addr;
  assign o_ce_n = r_q.pins.ce_n;
  assign o_we_n = r_q.pins.we_n;
  assign o_oe_n = r_q.pins.oe_n;

  // ==========================================================================
  // Checks
  sequence s_sel_fall;
    $fell(o_ce_n);
  endsequence

  // Eighteen cycles low, the initiation time rounded up
  sequence s_sel_held;
    !o_ce_n [*8] ##1 !o_ce_n [*8] ##1 !o_ce_n [*2];
  endsequence

  sequence s_sel_gap;
    o_ce_n [*2];
  endsequence

  a_write_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_we_n) // R14
    else $error("write strobe driven low");
  a_pulse_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R15
    s_sel_fall |-> !o_ce_n [*8])
    else $error("chip select pulse too short");
  a_pulse_exact: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R15
    s_sel_fall |-> s_sel_held ##1 o_ce_n)
    else $error("chip select pulse length wrong");
  a_gap_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R15
    $rose(o_ce_n) |-> s_sel_gap)
    else $error("chip select high too briefly");
  a_read_in_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R15
    s_sel_fall |-> o_busy)
    else $error("read outside a sequence");
  a_addr_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R6
    !o_ce_n |-> $stable(o_addr))
    else $error("address moved during select");
  a_first_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R1
    (s_sel_fall and (r_q.step == 3'h0)) |-> o_addr == nvs_pkg::SEQ_A0)
    else $error("sequence not started at first address");
  a_second_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R1
    (s_sel_fall and (r_q.step == 3'h1)) |-> o_addr == nvs_pkg::SEQ_A1)
    else $error("wrong second address");
  a_third_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R1
    (s_sel_fall and (r_q.step == 3'h2)) |-> o_addr == nvs_pkg::SEQ_A2)
    else $error("wrong third address");
  a_fourth_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R2
    (s_sel_fall and (r_q.step == 3'h3)) |-> o_addr == nvs_pkg::SEQ_A3)
    else $error("wrong fourth address");
  a_fifth_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R2
    (s_sel_fall and (r_q.step == 3'h4)) |-> o_addr == nvs_pkg::SEQ_A4)
    else $error("wrong fifth address");
  a_sixth_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R2 R3
    (s_sel_fall and (r_q.step == 3'h5)) |-> o_addr == (r_q.op == nvs_pkg::NVS_OP_RECALL ?
      nvs_pkg::SEQ_RECALL : nvs_pkg::SEQ_STORE))
    else $error("wrong sixth address");
  a_recall_time: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R13
    $rose(o_busy) && r_q.op == nvs_pkg::NVS_OP_RECALL
      |-> ##[1:1000] $fell(o_busy) || RECALL_CYC > 900)
    else $error("recall never finished");
  a_quiet_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R5
    r_q.st == nvs_pkg::NVS_BUSY |-> o_ce_n)
    else $error("bus touched during cycle");
  a_done_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R8
    o_done |-> !o_busy && o_ready ##1 !o_done)
    else $error("done not a single pulse");
  a_start_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R1
    i_start && o_ready |=> o_busy && !o_ready && o_addr == nvs_pkg::SEQ_A0)
    else $error("start not taken");
  a_op_held: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R6
    !o_ready |=> $stable(r_q.op))
    else $error("operation changed mid sequence");
  a_idle_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R6
    o_ready |-> o_ce_n)
    else $error("chip selected while idle");
  a_step_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R6
    r_q.step <= 3'h5)
    else $error("step beyond sixth read");
  a_gate_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R7
    o_oe_n)
    else $error("output gate driven low");
  a_last_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R2
    r_q.st == nvs_pkg::NVS_HIGH && r_q.step == 3'h5 |=> r_q.st == nvs_pkg::NVS_BUSY && o_ce_n)
    else $error("no wait after sixth read");
  a_store_limit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R17
    r_q.st == nvs_pkg::NVS_BUSY && r_q.op == nvs_pkg::NVS_OP_STORE |-> r_q.cnt < nvs_pkg::CNT_W'(STORE_CYC))
    else $error("store wait overran");
  a_recall_limit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R17
    r_q.st == nvs_pkg::NVS_BUSY && r_q.op == nvs_pkg::NVS_OP_RECALL |-> r_q.cnt < nvs_pkg::CNT_W'(RECALL_CYC))
    else $error("recall wait overran");
  a_done_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // R8
    $fell(o_busy) |-> o_done)
    else $error("busy ended without done");

endmodule // nvs_host_ctrl

// ---- tb/nvs_dev_model.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Device side: sequence matcher and nonvolatile cycle timer
module nvs_dev_model #(
  parameter int STORE_CYC = 50,
  parameter int RECALL_CYC = 20
) (
  input wire logic i_clk_sys,
  input wire logic [10:0] i_addr,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_pwr_fail,
  output int o_stores,
  output int o_recalls,
  output logic o_nv_busy
);
  logic [10:0] tab [5] = '{nvs_pkg::SEQ_A0, nvs_pkg::SEQ_A1, nvs_pkg::SEQ_A2, nvs_pkg::SEQ_A3, nvs_pkg::SEQ_A4};
  logic ce_q = 1'b1;
  logic [7:0] sram_q = 8'h5A;
  logic [7:0] nv_q = 8'h00;
  int step = 0;
  int left = 0;
  int n_st = 0;
  int n_rc = 0;
  assign o_stores = n_st;
  assign o_recalls = n_rc;
  assign o_nv_busy = (left != 0);
  always @(posedge i_clk_sys) begin
    ce_q <= i_ce_n;
    if (left != 0) begin
      left <= left - 1;
    end else if (ce_q && !i_ce_n) begin
      if (!i_we_n) begin
        step <= 0;
      end else if (step < 5) begin
        step <= (i_addr == tab[step]) ? step + 1 : ((i_addr == tab[0]) ? 1 : 0);
      end else begin
        step <= 0;
        if (i_addr == nvs_pkg::SEQ_STORE && !i_pwr_fail) begin
          nv_q <= sram_q;
          n_st <= n_st + 1;
          left <= STORE_CYC;
        end else if (i_addr == nvs_pkg::SEQ_RECALL) begin
          sram_q <= nv_q;
          n_rc <= n_rc + 1;
          left <= RECALL_CYC;
        end
      end
    end
  end
endmodule // nvs_dev_model

// ---- tb/test_nvs_host_ctrl.sv ----
`timescale 1ns/1ps
module test_nvs_host_ctrl;
  localparam int SC = 50;
  localparam int RC = 20;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, pf = 1'b0;
  nvs_pkg::nvs_op_t i_op = nvs_pkg::NVS_OP_STORE;
  logic o_ready, o_busy, o_done, o_ce_n, o_we_n, o_oe_n, nv_busy;
  logic [10:0] o_addr;
  int n_mismatch = 0, n_checks = 0, seed = 77313, stores, recalls, pulses = 0, low_cyc = 0;
  nvs_host_ctrl #(.STORE_CYC(SC), .RECALL_CYC(RC)) i_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_start(i_start), .i_op(i_op), .o_ready(o_ready), .o_busy(o_busy), .o_done(o_done), .o_addr(o_addr),
    .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n));
  nvs_dev_model #(.STORE_CYC(SC), .RECALL_CYC(RC)) i_dev (.i_clk_sys(i_clk_sys), .i_addr(o_addr),
    .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_pwr_fail(pf), .o_stores(stores), .o_recalls(recalls),
    .o_nv_busy(nv_busy));
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [10:0] exp_addr(nvs_pkg::nvs_op_t op, int idx);
    logic [10:0] t [6] = '{nvs_pkg::SEQ_A0, nvs_pkg::SEQ_A1, nvs_pkg::SEQ_A2, nvs_pkg::SEQ_A3, nvs_pkg::SEQ_A4,
      nvs_pkg::SEQ_STORE};
    if (idx == 5 && op == nvs_pkg::NVS_OP_RECALL) return nvs_pkg::SEQ_RECALL;
    return t[idx];
  endfunction
  // ==========================================================================
  // Pin monitor: each chip-select pulse is one sequence read
  always @(negedge o_ce_n) if (i_rst_n) begin
    check("seq_addr", o_addr, exp_addr(i_op, pulses));
    check("we_high", o_we_n, 1'b1);
    check("dev_idle", nv_busy, 1'b0);
    pulses++;
  end
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) low_cyc <= 0;
    else if (o_ce_n === 1'b0) low_cyc <= low_cyc + 1;
    else if (low_cyc != 0) begin
      check("ce_low", low_cyc, 18);
      low_cyc <= 0;
    end
  end
  // ==========================================================================
  // Random stores and recalls, power fail on some, start held into busy
  initial begin
    repeat (4) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    for (int k = 0; k < 12; k++) begin
      int cyc, s0, r0, hold;
      if (k == 3) begin
        // Reset cuts a recall after three reads; the device keeps a partial match
        @(posedge i_clk_sys);
        #1 i_op = nvs_pkg::NVS_OP_RECALL;
        i_start = 1'b1;
        pulses = 0;
        repeat (50) @(posedge i_clk_sys);
        #1 i_rst_n = 1'b0;
        i_start = 1'b0;
        #1 check("rst_sel", o_ce_n, 1'b1);
        check("rst_busy", o_busy, 1'b0);
        check("rst_ready", o_ready, 1'b1);
        check("rst_addr", o_addr, 11'h000);
        check("cut_pulses", pulses, 3);
        repeat (2) @(posedge i_clk_sys);
        #1 i_rst_n = 1'b1;
      end
      s0 = stores;
      r0 = recalls;
      hold = k < 3 ? 60 : ($random(seed) & 7);
      @(posedge i_clk_sys);
      #1 i_op = nvs_pkg::nvs_op_t'(k < 2 ? k[0] : $random(seed) & 1);
      pf = (k == 2) || ($random(seed) % 4 == 0);
      i_start = 1'b1;
      pulses = 0;
      cyc = 0;
      while (o_done !== 1'b1 && cyc < 5000) begin
        @(posedge i_clk_sys);
        cyc++;
        #1 if (cyc == 1) check("busy", o_busy, 1'b1);
        if (cyc >= hold) i_start = 1'b0;
      end
      if (cyc >= 5000) begin
        n_mismatch++;
        break;
      end
      i_start = 1'b0;
      check("done_time", cyc, 121 + (i_op == nvs_pkg::NVS_OP_STORE ? SC : RC));
      check("pulses", pulses, 6);
      check("ready", o_ready, 1'b1);
      check("stores", stores, s0 + (i_op == nvs_pkg::NVS_OP_STORE && !pf));
      check("recalls", recalls, r0 + (i_op == nvs_pkg::NVS_OP_RECALL));
    end
    complete_run();
  end
endmodule // test_nvs_host_ctrl
